//--- hw/status_byte_service_request.sv
/*
  Top of the status reporting tree: status summary byte, service
  request mask, standard event latch and its mask, service request.
  Assumes commands arrive already decoded, one per cycle, and that
  the lower registers deliver their summary bits as levels.
*/
// Summary of operation
// - Status byte readable by status query and by serial poll
// - Each status bit has a request mask bit; mask bit 6 ignored
// - Masked status bit rising raises a service request
// - Request mask written by its set command, echoed by its query
// - Status bit 2 set whenever an error queue entry is added
// - Enabled error bit: every new error entry requests service
// - Status bit 3 set while masked questionable event is present
// - Status bit 4 set while a response message waits
// - Status bit 5 is OR of event latch ANDed with event mask
// - Status bit 6 set when another masked status bit is set
// - Status bit 7 set while masked operation event is present
// - Event latch is an event part, read by its own query
// - Masked event latch bit rising sets the event summary bit
// - Event mask written by its set command, echoed by its query
// - Completion bit 0 set once all earlier commands finished
// - Bit 2 on read without query or command before fetch
// - Device error sets bit 3 and queues a -300 class error
// - Execution error sets bit 4 and queues a -200 class error
// - Command error sets bit 5 and queues a -100 class error
// - Bit 6 set on change over to local manual control
// - Bit 7 set at power up
// - Reading the event latch clears it
module status_byte_service_request (
  input wire logic clock_in, // System clock, 40 MHz
  input wire logic reset_in, // Synchronous power-on reset
  input wire status_pkg::command_s command_in, // Decoded command
  input wire logic error_queue_add_in, // Entry added elsewhere
  input wire logic error_queue_not_empty_in, // Queue holds entries
  input wire logic questionable_summary_in, // Lower sum bit
  input wire logic operation_summary_in, // Lower sum bit
  input wire logic output_message_pending_in, // Response waiting
  input wire logic prior_commands_done_in, // Nothing executing
  input wire logic controller_read_in, // Controller read attempt
  input wire logic command_received_in, // New command arrived
  input wire logic device_error_in, // Device-dependent error
  input wire logic execution_error_in, // Command not executable
  input wire logic command_error_in, // Undefined or malformed
  input wire logic local_control_in, // Switched to local control
  output status_pkg::answer_s answer_out, // Query answer
  output status_pkg::error_entry_s error_entry_out, // Queue push
  output logic service_request_out, // Service request pending
  output logic main_request_summary_out, // Status bit 6 copy
  output logic event_summary_bit_out // Status bit 5 copy
);
  import status_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [7:0] srq_mask;
  logic [7:0] event_mask;
  logic [7:0] event_latch;
  logic [7:0] status_byte;
  logic [7:0] prev_base;
  logic [7:0] base;
  logic [7:0] rise;
  logic [7:0] event_set;
  logic [0:0] request_q;
  logic main_request_summary;
  logic entry_added;
  logic query_error;
  logic request_set;
  logic latch_read;
  logic poll_read;
  logic completion_wait;
  error_entry_s next_error;
  answer_s next_answer;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Event latch query carries the clear side effect
  assign latch_read = command_in.valid
    && command_in.op == OP_QUERY_EVENT_LATCH;
  assign poll_read = command_in.valid
    && command_in.op == OP_SERIAL_POLL;

  // ----------------------------------------------------------------
  // Error classification
  // ----------------------------------------------------------------
  // One queue push per cycle; the most basic error class wins
  always_comb begin
    next_error = '0;
    if (command_error_in) begin
      next_error.valid = 1'b1;
      next_error.code = COMMAND_ERROR_CODE;
    end else if (execution_error_in) begin
      next_error.valid = 1'b1;
      next_error.code = EXECUTION_ERROR_CODE;
    end else if (device_error_in) begin
      next_error.valid = 1'b1;
      next_error.code = DEVICE_ERROR_CODE;
    end
  end

  // Queue push to the error queue
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      error_entry_out <= '0;
    end else begin
      error_entry_out <= next_error;
    end
  end

  // Our own pushes count as entries added as well
  assign entry_added = error_queue_add_in | next_error.valid;

  // Reading with nothing asked, or talking over an unread answer
  assign query_error =
    (controller_read_in && !output_message_pending_in)
    || (command_received_in && output_message_pending_in);

  // ----------------------------------------------------------------
  // Operation complete tracking
  // ----------------------------------------------------------------
  // Waits after the completion command until execution drains
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      completion_wait <= 1'b0;
    end else if (command_in.valid
        && command_in.op == OP_OPERATION_COMPLETE) begin
      completion_wait <= 1'b1;
    end else if (prior_commands_done_in) begin
      completion_wait <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Standard event latch
  // ----------------------------------------------------------------
  // Event sources; bit 1 has no source
  always_comb begin
    event_set = '0;
    event_set[EVT_OPERATION_COMPLETE] =
      completion_wait && prior_commands_done_in;
    event_set[EVT_QUERY_ERROR] = query_error;
    event_set[EVT_DEVICE_ERROR] = device_error_in;
    event_set[EVT_EXECUTION_ERROR] = execution_error_in;
    event_set[EVT_COMMAND_ERROR] = command_error_in;
    event_set[EVT_USER_REQUEST] = local_control_in;
  end

  // Power-on bit comes from the reset value of the latch
  sticky_flags #(
    .W(BYTE_W),
    .RESET_VALUE(EVENT_LATCH_RESET)
  ) event_latch_flags (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .set_in(event_set),
    .clear_in(latch_read),
    .value_out(event_latch)
  );

  // ----------------------------------------------------------------
  // Mask registers
  // ----------------------------------------------------------------
  // Request mask keeps bit 6 so it echoes back unchanged
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      srq_mask <= SRQ_MASK_RESET;
    end else if (command_in.valid
        && command_in.op == OP_SET_SRQ_MASK) begin
      srq_mask <= command_in.data;
    end
  end

  // Event mask
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      event_mask <= EVENT_MASK_RESET;
    end else if (command_in.valid
        && command_in.op == OP_SET_EVENT_MASK) begin
      event_mask <= command_in.data;
    end
  end

  // ----------------------------------------------------------------
  // Status summary byte
  // ----------------------------------------------------------------
  // Summary sources; bits 0, 1 and 6 stay zero here
  always_comb begin
    base = '0;
    base[STB_ERROR_QUEUE] =
      error_queue_not_empty_in | entry_added;
    base[STB_QUESTIONABLE] = questionable_summary_in;
    base[STB_OUTPUT_PENDING] = output_message_pending_in;
    base[STB_EVENT_SUMMARY] = |(event_latch & event_mask);
    base[STB_OPERATION] = operation_summary_in;
  end

  // Main summary ignores the mask bit of its own position
  assign main_request_summary = |(base & srq_mask & REQUEST_SOURCE_MASK);

  // Registered byte; the bit 6 slot carries the main summary
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      status_byte <= STATUS_RESET;
      prev_base <= STATUS_RESET;
    end else begin
      status_byte <= base | {1'b0, main_request_summary, 6'h00};
      prev_base <= base;
    end
  end

  // Copies for the lower-level consumers
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      main_request_summary_out <= 1'b0;
      event_summary_bit_out <= 1'b0;
    end else begin
      main_request_summary_out <= main_request_summary;
      event_summary_bit_out <= base[STB_EVENT_SUMMARY];
    end
  end

  // ----------------------------------------------------------------
  // Service request
  // ----------------------------------------------------------------
  // A masked rising bit requests service; each new error entry
  // does too, even if the error bit was already high
  assign rise = base & ~prev_base & srq_mask
    & REQUEST_SOURCE_MASK;
  assign request_set = (|rise)
    || (entry_added && srq_mask[STB_ERROR_QUEUE]);

  // Pending request is cleared by a serial poll, set wins
  sticky_flags #(
    .W(1),
    .RESET_VALUE(1'b0)
  ) request_flag (
    .clock_in(clock_in),
    .reset_in(reset_in),
    .set_in(request_set),
    .clear_in(poll_read),
    .value_out(request_q)
  );

  assign service_request_out = request_q[0];

  // ----------------------------------------------------------------
  // Query answers
  // ----------------------------------------------------------------
  // Serial poll shows the pending request in bit 6 instead
  always_comb begin
    next_answer = '0;
    if (command_in.valid) begin
      next_answer.valid = 1'b1;
      unique case (command_in.op)
        OP_QUERY_STATUS: next_answer.data = status_byte;
        OP_SERIAL_POLL: next_answer.data =
          {status_byte[7], request_q[0], status_byte[5:0]};
        OP_QUERY_SRQ_MASK: next_answer.data = srq_mask;
        OP_QUERY_EVENT_LATCH: next_answer.data = event_latch;
        OP_QUERY_EVENT_MASK: next_answer.data = event_mask;
        default: next_answer.valid = 1'b0;
      endcase
    end
  end

  // Answer register
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      answer_out <= '0;
    end else begin
      answer_out <= next_answer;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  AST_STATUS_QUERY: assert property (
    command_in.valid && command_in.op == OP_QUERY_STATUS
    |=> answer_out.valid && answer_out.data == $past(status_byte))
    else $error("status query answer wrong");

  AST_POLL_BIT6: assert property (
    poll_read |=> answer_out.data[6] == $past(service_request_out))
    else $error("serial poll bit 6 wrong");

  AST_BIT6_SUM: assert property (
    status_byte[6] == |(status_byte & $past(srq_mask) & 8'hbf))
    else $error("main summary bit wrong");

  AST_RISE_REQUEST: assert property (
    |rise |=> service_request_out)
    else $error("service request not raised");

  AST_ENTRY_REQUEST: assert property (
    error_queue_add_in && srq_mask[2] |=> service_request_out
    && status_byte[2])
    else $error("error entry did not request service");

  AST_MASK_ECHO: assert property (
    command_in.valid && command_in.op == OP_SET_SRQ_MASK
    ##1 command_in.valid && command_in.op == OP_QUERY_SRQ_MASK
    |=> answer_out.data == $past(command_in.data, 2))
    else $error("request mask not echoed");

  AST_EVENT_MASK_ECHO: assert property (
    command_in.valid && command_in.op == OP_QUERY_EVENT_MASK
    |=> answer_out.data == $past(event_mask))
    else $error("event mask not echoed");

  AST_EVENT_SUMMARY: assert property (
    status_byte[5] == $past(|(event_latch & event_mask)))
    else $error("event summary bit wrong");

  AST_READ_CLEARS: assert property (
    latch_read && event_set == 8'h00 |=> event_latch == 8'h00)
    else $error("event latch not cleared by read");

  AST_COMPLETION: assert property (
    completion_wait && prior_commands_done_in
    |=> event_latch[0] && (!completion_wait
    || $past(command_in.valid && command_in.op == OP_OPERATION_COMPLETE)))
    else $error("completion bit not set");

  AST_COMMAND_ERROR: assert property (
    command_error_in |=> event_latch[5] && error_entry_out.valid
    && error_entry_out.code == 16'hff9c)
    else $error("command error not recorded");

  AST_UNUSED_ZERO: assert property (
    status_byte[1:0] == 2'b00 && event_latch[1] == 1'b0)
    else $error("unused bit set");

endmodule

//--- include/status_pkg.sv
/*
  Constants, commands and carriers shared by the status byte and
  service request block.
  Assumes a single 40 MHz system clock and a synchronous reset.
*/
package status_pkg;

  // ----------------------------------------------------------------
  // Widths and bit positions
  // ----------------------------------------------------------------
  localparam int BYTE_W = 8;
  localparam int ERROR_CODE_W = 16;
  localparam int STB_ERROR_QUEUE = 2;
  localparam int STB_QUESTIONABLE = 3;
  localparam int STB_OUTPUT_PENDING = 4;
  localparam int STB_EVENT_SUMMARY = 5;
  localparam int STB_MAIN_SUMMARY = 6;
  localparam int STB_OPERATION = 7;
  localparam int EVT_OPERATION_COMPLETE = 0;
  localparam int EVT_QUERY_ERROR = 2;
  localparam int EVT_DEVICE_ERROR = 3;
  localparam int EVT_EXECUTION_ERROR = 4;
  localparam int EVT_COMMAND_ERROR = 5;
  localparam int EVT_USER_REQUEST = 6;
  localparam int EVT_POWER_ON = 7;

  // ----------------------------------------------------------------
  // Masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] REQUEST_SOURCE_MASK = 8'hbf;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] SRQ_MASK_RESET = 8'h00;
  localparam logic [7:0] EVENT_MASK_RESET = 8'h00;
  localparam logic [7:0] EVENT_LATCH_RESET = 8'h80;

  // Error numbers queued for each error class (two's complement)
  localparam logic [15:0] DEVICE_ERROR_CODE = 16'hfed4;
  localparam logic [15:0] EXECUTION_ERROR_CODE = 16'hff38;
  localparam logic [15:0] COMMAND_ERROR_CODE = 16'hff9c;

  // ----------------------------------------------------------------
  // Commands and carriers
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_QUERY_STATUS = 4'h1,
    OP_SERIAL_POLL = 4'h2,
    OP_SET_SRQ_MASK = 4'h3,
    OP_QUERY_SRQ_MASK = 4'h4,
    OP_QUERY_EVENT_LATCH = 4'h5,
    OP_SET_EVENT_MASK = 4'h6,
    OP_QUERY_EVENT_MASK = 4'h7,
    OP_OPERATION_COMPLETE = 4'h8
  } command_e;

  typedef struct packed {
    logic valid;
    command_e op;
    logic [7:0] data;
  } command_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } answer_s;

  typedef struct packed {
    logic valid;
    logic [15:0] code;
  } error_entry_s;

endpackage

//--- hw/sticky_flags.sv
/*
  A row of sticky flags: set by hardware, cleared together by one
  clear strobe, a set in the clearing cycle wins.
  Assumes one clock and a synchronous active-high reset.
*/
module sticky_flags #(
  parameter int W = 8,
  parameter logic [W-1:0] RESET_VALUE = '0
) (
  input wire logic clock_in, // System clock
  input wire logic reset_in, // Synchronous reset
  input wire logic [W-1:0] set_in, // Per-bit set pulses
  input wire logic clear_in, // Clear all bits
  output logic [W-1:0] value_out // Held flags
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  // Set beats clear so an event arriving during a read is not lost
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      value_out <= RESET_VALUE;
    end else if (clear_in) begin
      value_out <= set_in;
    end else begin
      value_out <= value_out | set_in;
    end
  end

endmodule

//--- testbench/remote_controller_model.sv
/*
  Behavioural model of the remote test controller that issues decoded
  commands to the status block.
  Assumes the bench moves go_in just after a clock edge and holds it
  high for as many cycles as it has commands in a row.
*/
module remote_controller_model (
  input wire logic go_in, // Issue a command this cycle
  input wire status_pkg::command_e op_in, // Command code
  input wire logic [7:0] data_in, // Command argument
  output status_pkg::command_s command_out // Command toward the device
);
  timeunit 1ns;
  timeprecision 100ps;
  import status_pkg::*;

  // ----------------------------------------------------------------
  // Command shaping
  // ----------------------------------------------------------------
  // Idle argument is driven inverted, so a stale value never looks held
  always_comb begin
    command_out.valid = go_in;
    command_out.op = go_in ? op_in : OP_NONE;
    command_out.data = go_in ? data_in : ~data_in;
  end
endmodule

//--- testbench/status_byte_service_request_bench.sv
/*
  Self-checking bench for the status byte and service request block.
  Assumes the command port answers queries one cycle after the take.
*/
module status_byte_service_request_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import status_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clock_in;
  logic reset_in;
  logic go;
  command_e op;
  logic [7:0] op_data;
  logic [6:0] strobes;
  logic [4:0] levels;
  command_s command;
  answer_s answer;
  error_entry_s error_entry;
  logic service_request;
  logic main_summary;
  logic event_summary;
  int errors;
  int samples_checked;
  int cycles;
  logic [7:0] status_bits [4] = '{8'h04, 8'h08, 8'h10, 8'h80};
  logic [15:0] error_codes [3] = '{16'hfed4, 16'hff38, 16'hff9c};
  logic [7:0] mask_values [3] = '{8'hff, 8'h5a, 8'h00};

  remote_controller_model remote_controller_model_i (
    .go_in(go), .op_in(op), .data_in(op_data), .command_out(command));

  status_byte_service_request status_byte_service_request_i (
    .clock_in(clock_in), .reset_in(reset_in), .command_in(command),
    .error_queue_add_in(strobes[0]), .error_queue_not_empty_in(levels[0]),
    .questionable_summary_in(levels[1]), .operation_summary_in(levels[3]),
    .output_message_pending_in(levels[2]), .prior_commands_done_in(levels[4]),
    .controller_read_in(strobes[1]), .command_received_in(strobes[2]),
    .device_error_in(strobes[3]), .execution_error_in(strobes[4]),
    .command_error_in(strobes[5]), .local_control_in(strobes[6]),
    .answer_out(answer), .error_entry_out(error_entry),
    .service_request_out(service_request),
    .main_request_summary_out(main_summary),
    .event_summary_bit_out(event_summary));

  // ----------------------------------------------------------------
  // Clock and hang guard
  // ----------------------------------------------------------------
  // Free-running 40 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end

  // The sequence needs under a hundred cycles; 3000 means a hang
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, expected);
    end
  endtask

  // Inputs always move a fixed 2 ns after the edge, never on it;
  // the command strobe drops only here, so back-to-back commands
  // keep it up instead of lowering and raising it in one step
  task automatic tick(input int n);
    go = 1'b0;
    repeat (n) @(posedge clock_in);
    #2;
  endtask

  // Answer is taken while it stands, in the cycle after the take
  task automatic cmd(input command_e c, input logic [7:0] d, output logic [8:0] reply);
    op = c;
    op_data = d;
    go = 1'b1;
    @(posedge clock_in);
    #2;
    reply = {answer.valid, answer.data};
  endtask

  task automatic query(input command_e c, input logic [7:0] expected);
    logic [8:0] reply;
    cmd(c, 8'h00, reply);
    check({7'h00, reply}, {8'h01, expected});
  endtask

  // Set commands and refused codes must stay silent
  task automatic write(input command_e c, input logic [7:0] d);
    logic [8:0] reply;
    cmd(c, d, reply);
    check({15'h0000, reply[8]}, 16'h0000);
  endtask

  task automatic pulse(input int b);
    strobes[b] = 1'b1;
    tick(1);
    strobes = '0;
  endtask

  task automatic end_of_test();
    $display("Checked %0d values, %0d mismatches", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [8:0] ignored;
    errors = 0;
    samples_checked = 0;
    cycles = 0;
    reset_in = 1'b1;
    op = OP_NONE;
    op_data = 8'h00;
    strobes = '0;
    levels = '0;
    tick(5);
    reset_in = 1'b0;
    // Power-on bit reads once, then the read has cleared it
    query(OP_QUERY_EVENT_LATCH, 8'h80);
    query(OP_QUERY_EVENT_LATCH, 8'h00);
    query(OP_QUERY_STATUS, 8'h00);
    write(OP_NONE, 8'hff);
    // Masks written and echoed back to back
    for (int i = 0; i < 3; i++) begin
      write(OP_SET_SRQ_MASK, mask_values[i]);
      query(OP_QUERY_SRQ_MASK, mask_values[i]);
      write(OP_SET_EVENT_MASK, mask_values[i]);
      query(OP_QUERY_EVENT_MASK, mask_values[i]);
    end
    // Each lower summary source lands on its own status bit
    for (int i = 0; i < 4; i++) begin
      levels = 5'(1 << i);
      tick(2);
      query(OP_QUERY_STATUS, status_bits[i]);
      check({15'h0000, main_summary}, 16'h0000);
    end
    levels = '0;
    // Masked pending message raises a request; poll reports then clears it
    write(OP_SET_SRQ_MASK, 8'h10);
    levels = 5'h04;
    tick(2);
    check({15'h0000, service_request}, 16'h0001);
    check({15'h0000, main_summary}, 16'h0001);
    query(OP_QUERY_STATUS, 8'h50);
    query(OP_SERIAL_POLL, 8'h50);
    check({15'h0000, service_request}, 16'h0000);
    query(OP_QUERY_STATUS, 8'h50);
    levels = '0;
    // Mask bit 6 alone must not form a request
    write(OP_SET_SRQ_MASK, 8'h40);
    levels = 5'h0f;
    tick(2);
    query(OP_QUERY_STATUS, 8'h9c);
    check({15'h0000, service_request}, 16'h0000);
    // Queue already not empty: no rise on bit 2, yet each entry requests
    levels = 5'h01;
    // Every new error entry requests service when enabled
    write(OP_SET_SRQ_MASK, 8'h04);
    for (int i = 0; i < 2; i++) begin
      pulse(0);
      tick(1);
      check({15'h0000, service_request}, 16'h0001);
      cmd(OP_SERIAL_POLL, 8'h00, ignored);
    end
    levels = '0;
    write(OP_SET_SRQ_MASK, 8'h00);
    tick(2);
    cmd(OP_SERIAL_POLL, 8'h00, ignored);
    query(OP_QUERY_EVENT_LATCH, 8'h00);
    // Error classes and local control each set their own latch bit
    for (int i = 0; i < 4; i++) begin
      pulse(3 + i);
      check({15'h0000, error_entry.valid}, {15'h0000, i < 3});
      if (i < 3) check(error_entry.code, error_codes[i]);
      query(OP_QUERY_EVENT_LATCH, 8'(8'h08 << i));
    end
    // Enabled latch bit drives the event summary until read away
    write(OP_SET_EVENT_MASK, 8'h08);
    pulse(3);
    tick(1);
    check({15'h0000, event_summary}, 16'h0001);
    query(OP_QUERY_EVENT_LATCH, 8'h08);
    tick(1);
    check({15'h0000, event_summary}, 16'h0000);
    write(OP_SET_EVENT_MASK, 8'h00);
    // Read with nothing to fetch, then new command over an unfetched reply
    pulse(1);
    query(OP_QUERY_EVENT_LATCH, 8'h04);
    levels = 5'h04;
    pulse(2);
    query(OP_QUERY_EVENT_LATCH, 8'h04);
    levels = '0;
    // Completion waits for earlier commands to finish
    write(OP_OPERATION_COMPLETE, 8'h00);
    tick(3);
    query(OP_QUERY_EVENT_LATCH, 8'h00);
    levels = 5'h10;
    tick(2);
    query(OP_QUERY_EVENT_LATCH, 8'h01);
    end_of_test();
  end
endmodule
